// >>> core/simd_gate_pkg.sv
// shared constants and types for the simd extension gating block
package simd_gate_pkg;

    // register bus geometry
    localparam int ADDR_W = 8;             // byte address width
    localparam int DATA_W = 32;            // register data width

    // register byte offsets, one aligned word each
    localparam logic [7:0] REG_CTRL0  = 8'h00; // control_reg0
    localparam logic [7:0] REG_CTRL4  = 8'h04; // control_reg4
    localparam logic [7:0] REG_FLAGS  = 8'h08; // flags_register
    localparam logic [7:0] REG_PRIV   = 8'h0c; // current_privilege
    localparam logic [7:0] REG_ID_D   = 8'h10; // identify leaf 1, reg d
    localparam logic [7:0] REG_ID_C   = 8'h14; // identify leaf 1, reg c
    localparam logic [7:0] REG_SCS    = 8'h18; // simd_control_status
    localparam logic [7:0] REG_STATUS = 8'h1c; // last verdict

    // control_reg0 fields
    localparam int CR0_MON = 1;            // monitor_coproc
    localparam int CR0_EMU = 2;            // fpu_emulate
    localparam int CR0_TS  = 3;            // task_switched
    localparam int CR0_AM  = 18;           // align_mask
    // control_reg4 fields
    localparam int CR4_FXS = 9;            // os_fxstate_support
    localparam int CR4_XMM = 10;           // os_simd_fp_handler_enable
    // flags_register field
    localparam int FLG_AC  = 18;           // align_check_flag
    // identify leaf 1 feature positions
    localparam int ID_D_FXSR = 24;         // state save and restore
    localparam int ID_D_SSE  = 25;         // first generation
    localparam int ID_D_SSE2 = 26;         // second generation
    localparam int ID_C_SSE3 = 0;          // third generation

    // reset values
    localparam logic [31:0] CTRL0_RST = 32'h0000_0000;
    localparam logic [31:0] CTRL4_RST = 32'h0000_0000;
    localparam logic [31:0] FLAGS_RST = 32'h0000_0000;
    localparam logic [31:0] SCS_RST   = 32'h0000_0000; // masks, ftz, daz, rc
    localparam logic [1:0]  PRIV_RST  = 2'h0;
    localparam logic [1:0]  PRIV_USER = 2'h3;          // least privileged

    // 128-bit operands must sit on a 16-byte boundary
    localparam logic [3:0] ALIGN_128 = 4'hf;

    // instruction classes
    typedef enum logic [2:0] {
        IC_GATED  = 3'h1,                  // ordinary simd instruction
        IC_EXEMPT = 3'h2,                  // pause, prefetch, fences, etc.
        IC_UMOVE  = 3'h4                   // unaligned single/double move
    } iclass_t;

    // memory operand sizes
    typedef enum logic [3:0] {
        SZ_16  = 4'h1,
        SZ_32  = 4'h2,
        SZ_64  = 4'h4,
        SZ_128 = 4'h8
    } opsize_t;

    // verdicts, one-hot
    typedef enum logic [6:0] {
        ACT_EXEC = 7'h01,                  // execute
        ACT_UD   = 7'h02,                  // invalid_opcode_fault
        ACT_NM   = 7'h04,                  // device_unavailable_fault
        ACT_GP   = 7'h08,                  // general_protection_fault
        ACT_AC   = 7'h10,                  // alignment_fault
        ACT_MEMF = 7'h20,                  // forwarded memory fault
        ACT_NONE = 7'h40                   // idle
    } action_t;

    // one instruction offered for gating
    typedef struct packed {
        iclass_t    iclass;                // class of instruction
        logic [2:0] gen;                   // one-hot generation needed
        logic       has_mem;               // has a memory operand
        opsize_t    size;                  // operand size
        logic       stack_seg;             // operand in stack segment
        logic [3:0] addr_lo;               // low address bits
    } issue_t;

    // answer for one instruction
    typedef struct packed {
        logic    valid;                    // verdict present
        action_t action;                   // what happens
    } verdict_t;

endpackage : simd_gate_pkg

// >>> core/simd_align_check.sv
// alignment checks on simd memory operands
`timescale 1ns/1ps
`default_nettype none

module simd_align_check (
    input  wire simd_gate_pkg::issue_t issue,     // instruction offered
    input  wire logic                  align_on,  // am, ac and user level
    output var  logic                  gp_align,  // 128-bit misaligned
    output var  logic                  ac_fault   // small misaligned
);

    // low address bits that must be zero for a given size
    function automatic logic [3:0] size_mask(
        input simd_gate_pkg::opsize_t sz
    );
        case (sz)
            simd_gate_pkg::SZ_16:  size_mask = 4'h1;
            simd_gate_pkg::SZ_32:  size_mask = 4'h3;
            simd_gate_pkg::SZ_64:  size_mask = 4'h7;
            simd_gate_pkg::SZ_128: size_mask = simd_gate_pkg::ALIGN_128;
            default:               size_mask = 4'h0;
        endcase
    endfunction : size_mask

    wire logic is_128;                     // full-width operand
    wire logic misal;                      // operand off its boundary
    wire logic umove;                      // unaligned move class

    assign is_128 = (issue.size == simd_gate_pkg::SZ_128);
    assign misal  = issue.has_mem
                  && ((issue.addr_lo & size_mask(issue.size)) != 4'h0);
    assign umove  = (issue.iclass == simd_gate_pkg::IC_UMOVE);

    // stack segment gives gp too, never a stack fault
    always_comb
    begin
        gp_align = is_128 && misal && !umove;
    end

    // 128-bit is never alignment-checked, unaligned moves included
    always_comb
    begin
        ac_fault = align_on && misal && !is_128;
    end

endmodule : simd_align_check

`default_nettype wire

// >>> core/simd_ext_exception_gating.sv
// gating and fault selection for packed simd extension instructions
//
// Added by the designer: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module simd_ext_exception_gating #(
    parameter bit HAS_SSE  = 1'b1,         // first generation built
    parameter bit HAS_SSE2 = 1'b1,         // second generation built
    parameter bit HAS_SSE3 = 1'b1,         // third generation built
    parameter bit HAS_FXSR = 1'b1          // state save/restore built
) (
    input  wire logic                    core_clk,     // core clock
    input  wire logic                    reset_n,      // async, low
    input  wire logic [7:0]              reg_addr,     // byte address
    input  wire logic [31:0]             reg_wdata,    // write data
    input  wire logic                    reg_wr,       // write strobe
    input  wire logic                    reg_rd,       // read strobe
    output var  logic [31:0]             reg_rdata,    // read data
    output var  logic                    wr_gp,        // refused write
    input  wire logic                    issue_valid,  // instr offered
    input  wire simd_gate_pkg::issue_t   issue,        // instr fields
    input  wire logic                    mem_fault_in, // mmu fault
    input  wire logic                    numeric_valid,// unmasked fp
    output var  simd_gate_pkg::verdict_t verdict,      // gating answer
    output var  logic                    num_xf,       // simd_fp_fault
    output var  logic                    num_ud        // invalid opcode
);

    // a third generation without the two earlier ones cannot be served
    if (HAS_SSE3
        && !(HAS_SSE && HAS_SSE2))
    begin : g_bad_cfg
        $error("third generation needs the earlier generations");
    end

    // architectural state held here
    logic [31:0] ctrl0;                    // control_reg0
    logic [31:0] ctrl4;                    // control_reg4
    logic [31:0] flags;                    // flags_register
    logic [1:0]  priv;                     // current_privilege
    logic [31:0] scs;                      // simd_control_status
    logic [6:0]  last_act;                 // last verdict seen

    // bus decode
    wire logic wr_c0;                      // write control_reg0
    wire logic wr_c4;                      // write control_reg4
    wire logic wr_fl;                      // write flags
    wire logic wr_pr;                      // write privilege
    wire logic wr_sc;                      // write control/status
    wire logic c4_refuse;                  // fxstate set without save
    logic [31:0] id_d;                     // identify reg d image
    logic [31:0] id_c;                     // identify reg c image
    wire logic [31:0] rd_mux;              // selected read value

    assign wr_c0 = reg_wr && (reg_addr == simd_gate_pkg::REG_CTRL0);
    assign wr_c4 = reg_wr && (reg_addr == simd_gate_pkg::REG_CTRL4);
    assign wr_fl = reg_wr && (reg_addr == simd_gate_pkg::REG_FLAGS);
    assign wr_pr = reg_wr && (reg_addr == simd_gate_pkg::REG_PRIV);
    assign wr_sc = reg_wr && (reg_addr == simd_gate_pkg::REG_SCS);

    // no save/restore means the enable cannot be set at all
    assign c4_refuse = wr_c4 && !HAS_FXSR
                     && reg_wdata[simd_gate_pkg::CR4_FXS];

    // feature report images, built straight from the build parameters
    always_comb
    begin
        id_d = 32'h0000_0000;
        id_d[simd_gate_pkg::ID_D_FXSR] = HAS_FXSR;
        id_d[simd_gate_pkg::ID_D_SSE]  = HAS_SSE;
        id_d[simd_gate_pkg::ID_D_SSE2] = HAS_SSE2;
    end

    always_comb
    begin
        id_c = 32'h0000_0000;
        id_c[simd_gate_pkg::ID_C_SSE3] = HAS_SSE3;
    end

    // read select; unmapped offsets answer zero
    assign rd_mux =
        (reg_addr == simd_gate_pkg::REG_CTRL0)  ? ctrl0 :
        (reg_addr == simd_gate_pkg::REG_CTRL4)  ? ctrl4 :
        (reg_addr == simd_gate_pkg::REG_FLAGS)  ? flags :
        (reg_addr == simd_gate_pkg::REG_PRIV)   ? {30'h0, priv} :
        (reg_addr == simd_gate_pkg::REG_ID_D)   ? id_d :
        (reg_addr == simd_gate_pkg::REG_ID_C)   ? id_c :
        (reg_addr == simd_gate_pkg::REG_SCS)    ? scs :
        (reg_addr == simd_gate_pkg::REG_STATUS) ? {25'h0, last_act} :
        32'h0000_0000;

    // control_reg0, all bits software-owned
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            ctrl0 <= simd_gate_pkg::CTRL0_RST;
        else if (wr_c0)
            ctrl0 <= reg_wdata;
    end

    // control_reg4; a refused write leaves the whole word alone
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            ctrl4 <= simd_gate_pkg::CTRL4_RST;
        else if (wr_c4 && !c4_refuse)
            ctrl4 <= reg_wdata;
    end

    // flags and privilege level
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            flags <= simd_gate_pkg::FLAGS_RST;
            priv  <= simd_gate_pkg::PRIV_RST;
        end
        else
        begin
            if (wr_fl)
                flags <= reg_wdata;
            if (wr_pr)
                priv <= reg_wdata[1:0];
        end
    end

    // control/status starts with masks, ftz, daz, rounding at zero
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            scs <= simd_gate_pkg::SCS_RST;
        else if (wr_sc)
            scs <= reg_wdata;
    end

    // read data stands one cycle, zero otherwise
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            reg_rdata <= 32'h0000_0000;
            wr_gp     <= 1'b0;
        end
        else
        begin
            reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
            wr_gp     <= c4_refuse;
        end
    end

    // gating terms; os support comes only from control_reg4
    wire logic os_fx;                      // os_fxstate_support
    wire logic os_xmm;                     // os_simd_fp_handler_enable
    wire logic emu;                        // fpu_emulate
    wire logic ts;                         // task_switched
    wire logic feat_ok;                    // generation is built
    wire logic gated;                      // subject to gating
    wire logic align_on;                   // alignment checks live
    wire logic gp_align;                   // 128-bit misalignment
    wire logic ac_hit;                     // small misalignment
    wire logic gate_ud;                    // invalid opcode case
    wire logic gate_nm;                    // device unavailable case
    simd_gate_pkg::action_t next_act;      // chosen verdict

    assign os_fx   = ctrl4[simd_gate_pkg::CR4_FXS];
    assign os_xmm  = ctrl4[simd_gate_pkg::CR4_XMM];
    assign emu     = ctrl0[simd_gate_pkg::CR0_EMU];
    assign ts      = ctrl0[simd_gate_pkg::CR0_TS];
    assign feat_ok = (issue.gen & {HAS_SSE3, HAS_SSE2, HAS_SSE}) != 3'h0;
    assign gated   = (issue.iclass != simd_gate_pkg::IC_EXEMPT);
    assign align_on = ctrl0[simd_gate_pkg::CR0_AM]
                    && flags[simd_gate_pkg::FLG_AC]
                    && (priv == simd_gate_pkg::PRIV_USER);

    // emulate wins whatever task_switched says
    assign gate_ud = gated
                   && (!os_fx || !feat_ok || emu);
    assign gate_nm = gated && ts;

    // operand alignment
    simd_align_check u_align (
        .issue    (issue),
        .align_on (align_on),
        .gp_align (gp_align),
        .ac_fault (ac_hit)
    );

    // priority: gating faults first, so no memory access starts
    always_comb
    begin
        if (!issue_valid)
            next_act = simd_gate_pkg::ACT_NONE;
        else if (gate_ud)
            next_act = simd_gate_pkg::ACT_UD;
        else if (gate_nm)
            next_act = simd_gate_pkg::ACT_NM;
        else if (gp_align)
            next_act = simd_gate_pkg::ACT_GP;
        else if (ac_hit)
            next_act = simd_gate_pkg::ACT_AC;
        else if (mem_fault_in && issue.has_mem)
            next_act = simd_gate_pkg::ACT_MEMF;
        else
            next_act = simd_gate_pkg::ACT_EXEC;
    end

    // verdict register, one cycle after the offer
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            verdict.valid  <= 1'b0;
            verdict.action <= simd_gate_pkg::ACT_NONE;
        end
        else
        begin
            verdict.valid  <= issue_valid;
            verdict.action <= next_act;
        end
    end

    // last verdict kept for software to inspect
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            last_act <= simd_gate_pkg::ACT_NONE;
        else if (issue_valid)
            last_act <= next_act;
    end

    // numeric report; the ne bit and pin never enter here
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            num_xf <= 1'b0;
            num_ud <= 1'b0;
        end
        else
        begin
            num_xf <= numeric_valid && os_xmm;
            num_ud <= numeric_valid && !os_xmm;
        end
    end

    // checks on the gating behaviour
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    property p_emu_ud;
        issue_valid && gated && emu
            |=> verdict.action == simd_gate_pkg::ACT_UD;
    endproperty
    a_emu_ud: assert property (p_emu_ud)
        else $error("emulate set but no invalid opcode");

    property p_os_ud;
        issue_valid && gated && !os_fx
            |=> verdict.valid && verdict.action == simd_gate_pkg::ACT_UD;
    endproperty
    a_os_ud: assert property (p_os_ud)
        else $error("os support off but no invalid opcode");

    property p_ts_nm;
        issue_valid && gated && os_fx && feat_ok && !emu && ts
            |=> verdict.action == simd_gate_pkg::ACT_NM;
    endproperty
    a_ts_nm: assert property (p_ts_nm)
        else $error("task switched but no device unavailable");

    property p_exempt;
        issue_valid && !gated
            |=> !(verdict.action inside {simd_gate_pkg::ACT_UD,
                                         simd_gate_pkg::ACT_NM});
    endproperty
    a_exempt: assert property (p_exempt)
        else $error("exempt instruction was gated");

    property p_num_xf;
        numeric_valid && os_xmm |=> num_xf && !num_ud;
    endproperty
    a_num_xf: assert property (p_num_xf)
        else $error("numeric fault not reported as simd fault");

    property p_num_ud;
        numeric_valid && !os_xmm |=> num_ud && !num_xf;
    endproperty
    a_num_ud: assert property (p_num_ud)
        else $error("numeric fault without handler not invalid opcode");

    property p_wr_gp;
        c4_refuse |=> wr_gp ##1 !ctrl4[simd_gate_pkg::CR4_FXS] || wr_c4;
    endproperty
    a_wr_gp: assert property (p_wr_gp)
        else $error("fxstate set without save support not refused");

    property p_ac_cond;
        verdict.action == simd_gate_pkg::ACT_AC && verdict.valid
            |-> $past(align_on);
    endproperty
    a_ac_cond: assert property (p_ac_cond)
        else $error("alignment fault with checking disabled");

    property p_id_read;
        reg_rd && reg_addr == simd_gate_pkg::REG_ID_D
            |=> reg_rdata[simd_gate_pkg::ID_D_SSE] == HAS_SSE
             && reg_rdata[simd_gate_pkg::ID_D_FXSR] == HAS_FXSR;
    endproperty
    a_id_read: assert property (p_id_read)
        else $error("identify feature bits wrong");

    property p_gp_128;
        issue_valid && !gate_ud && !gate_nm && issue.has_mem
            && issue.size == simd_gate_pkg::SZ_128
            && issue.iclass == simd_gate_pkg::IC_GATED
            && issue.addr_lo != 4'h0
            |=> verdict.action == simd_gate_pkg::ACT_GP;
    endproperty
    a_gp_128: assert property (p_gp_128)
        else $error("misaligned 128-bit operand not refused");

endmodule : simd_ext_exception_gating

`default_nettype wire

// >>> verif/test_simd_ext_exception_gating.sv
// self-checking bench for the simd extension gating block
`timescale 1ns/1ps
`default_nettype none

module test_simd_ext_exception_gating;
    logic                         core_clk      = 1'b0;  // 40 MHz clock
    logic                         reset_n       = 1'b0;  // async, low
    logic [7:0]                   reg_addr      = 8'h00; // byte address
    logic [31:0]                  reg_wdata     = 32'h0; // write data
    logic                         reg_wr        = 1'b0;  // write strobe
    logic                         reg_rd        = 1'b0;  // read strobe
    logic                         issue_valid   = 1'b0;  // instr offered
    simd_gate_pkg::issue_t        iss           = '0;    // instr fields
    logic                         mem_fault_in  = 1'b0;  // mmu fault
    logic                         numeric_valid = 1'b0;  // unmasked fp
    wire logic [31:0]             rdata, rdata_b;        // full / bare
    wire logic                    gp, gp_b;              // refused write
    wire simd_gate_pkg::verdict_t vd, vd_b;              // verdicts
    wire logic                    xf, xf_b, ud, ud_b;    // numeric report
    int err_count = 0;                                   // mismatches
    int cmp_count = 0;                                   // comparisons
    int seed      = 65;                                  // fixed seed
    int cycles    = 0;                                   // hang guard
    logic [31:0] m_c0, m_c4, m_c4b, m_fl;                // register mirrors
    logic [1:0]  m_pv;                                   // privilege mirror
    simd_gate_pkg::iclass_t cls [3] = '{simd_gate_pkg::IC_GATED,
        simd_gate_pkg::IC_EXEMPT, simd_gate_pkg::IC_UMOVE};
    simd_gate_pkg::opsize_t szs [4] = '{simd_gate_pkg::SZ_16,
        simd_gate_pkg::SZ_32, simd_gate_pkg::SZ_64, simd_gate_pkg::SZ_128};

    // full build and a build with no extensions and no state save
    simd_ext_exception_gating u_dut (.core_clk(core_clk), .reset_n(reset_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(rdata), .wr_gp(gp),
        .issue_valid(issue_valid), .issue(iss), .mem_fault_in(mem_fault_in),
        .numeric_valid(numeric_valid), .verdict(vd), .num_xf(xf),
        .num_ud(ud));
    simd_ext_exception_gating #(.HAS_SSE(1'b0), .HAS_SSE2(1'b0),
        .HAS_SSE3(1'b0), .HAS_FXSR(1'b0)) u_bare (.core_clk(core_clk),
        .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata_b), .wr_gp(gp_b),
        .issue_valid(issue_valid), .issue(iss), .mem_fault_in(mem_fault_in),
        .numeric_valid(numeric_valid), .verdict(vd_b), .num_xf(xf_b),
        .num_ud(ud_b));

    // 25 ns period
    always #12.5 core_clk = ~core_clk;

    // hang guard, far above the roughly two thousand cycles the run needs
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            err_count++;
            conclude();
        end
    end

    // one comparison, counted
    task automatic check(logic [31:0] seen, logic [31:0] exp, string what);
        cmp_count++;
        if (seen !== exp)
        begin
            err_count++;
            $display("wrong value at %0t: %s seen %h want %h",
                     $time, what, seen, exp);
        end
    endtask : check

    // expected verdict, priority order from the top down
    function automatic simd_gate_pkg::action_t exp_act(
        simd_gate_pkg::issue_t i, logic [31:0] c4, logic built, logic mf);
        logic gated, mis, aon;
        gated = (i.iclass != simd_gate_pkg::IC_EXEMPT);
        aon   = m_c0[18] && m_fl[18] && (m_pv == 2'h3);
        case (i.size)
            simd_gate_pkg::SZ_16: mis = i.addr_lo[0];
            simd_gate_pkg::SZ_32: mis = |i.addr_lo[1:0];
            simd_gate_pkg::SZ_64: mis = |i.addr_lo[2:0];
            default:              mis = |i.addr_lo;
        endcase
        if (gated && (!c4[9] || !built || m_c0[2]))
            return simd_gate_pkg::ACT_UD;
        if (gated && m_c0[3])
            return simd_gate_pkg::ACT_NM;
        if (i.has_mem && i.size == simd_gate_pkg::SZ_128 && mis
            && i.iclass != simd_gate_pkg::IC_UMOVE)
            return simd_gate_pkg::ACT_GP;
        if (i.has_mem && i.size != simd_gate_pkg::SZ_128 && mis && aon)
            return simd_gate_pkg::ACT_AC;
        if (i.has_mem && mf)
            return simd_gate_pkg::ACT_MEMF;
        return simd_gate_pkg::ACT_EXEC;
    endfunction : exp_act

    // one register write; only the bare build may refuse fxstate
    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge core_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        #1;
        check({31'h0, gp}, 32'h0, "refusal full");
        check({31'h0, gp_b},
              {31'h0, a == simd_gate_pkg::REG_CTRL4
                      && d[simd_gate_pkg::CR4_FXS]}, "refusal bare");
    endtask : wr

    // one register read, masked compare on both builds
    task automatic rd(logic [7:0] a, logic [31:0] e, logic [31:0] eb,
                      logic [31:0] m, string w);
        @(posedge core_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        check(rdata & m, e, w);
        check(rdata_b & m, eb, w);
    endtask : rd

    // offer one instruction, verdict stands in the next cycle
    task automatic offer(simd_gate_pkg::issue_t i, logic mf, logic nv);
        simd_gate_pkg::action_t ea, eb;
        logic hx, hb;
        hx = m_c4[10];
        hb = m_c4b[10];
        ea = exp_act(i, m_c4, 1'b1, mf);
        eb = exp_act(i, m_c4b, 1'b0, mf);
        @(posedge core_clk);
        issue_valid   <= 1'b1;
        iss           <= i;
        mem_fault_in  <= mf;
        numeric_valid <= nv;
        @(posedge core_clk);
        issue_valid   <= 1'b0;
        numeric_valid <= 1'b0;
        #1;
        check(32'(vd), {24'h0, 1'b1, ea}, "verdict");
        check(32'(vd_b), {24'h0, 1'b1, eb}, "verdict bare");
        check({30'h0, xf, ud}, {30'h0, nv & hx, nv & !hx}, "num");
        check({30'h0, xf_b, ud_b},
              {30'h0, nv & hb, nv & !hb}, "num bare");
    endtask : offer

    // build a memory-operand instruction
    function automatic simd_gate_pkg::issue_t mk(simd_gate_pkg::iclass_t c,
        simd_gate_pkg::opsize_t s, logic [3:0] a, logic st);
        return '{iclass: c, gen: 3'h1, has_mem: 1'b1, size: s,
                 stack_seg: st, addr_lo: a};
    endfunction : mk

    // verdict and end of run
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : conclude

    // main sequence: reset, registers, corners, random traffic
    initial
    begin
        simd_gate_pkg::issue_t i;
        {m_c0, m_c4, m_c4b, m_fl, m_pv} = '0;
        repeat (10) @(posedge core_clk);
        reset_n <= 1'b1;
        #1;
        check(32'(vd), {24'h0, 1'b0, simd_gate_pkg::ACT_NONE}, "idle");
        wr(simd_gate_pkg::REG_ID_D, 32'hffff_ffff);
        rd(simd_gate_pkg::REG_ID_D, 32'h0700_0000, 32'h0,
           32'hffff_ffff, "id d");
        rd(simd_gate_pkg::REG_ID_C, 32'h1, 32'h0,
           32'hffff_ffff, "id c");
        rd(simd_gate_pkg::REG_SCS, 32'h0, 32'h0,
           32'hffff_ffff, "scs");
        rd(8'h20, 32'h0, 32'h0, 32'hffff_ffff, "unmapped");
        m_c4 = 32'h0000_0600;
        wr(simd_gate_pkg::REG_CTRL4, m_c4);
        rd(simd_gate_pkg::REG_CTRL4, m_c4, 32'h0,
           32'hffff_ffff, "cr4");
        offer(mk(simd_gate_pkg::IC_GATED, simd_gate_pkg::SZ_128,
                 4'h8, 1'b1), 1'b0, 1'b1);
        offer(mk(simd_gate_pkg::IC_UMOVE, simd_gate_pkg::SZ_128,
                 4'h8, 1'b0), 1'b1, 1'b0);
        // last verdict kept: forwarded fault on full, invalid opcode on bare
        rd(simd_gate_pkg::REG_STATUS, 32'(simd_gate_pkg::ACT_MEMF),
           32'(simd_gate_pkg::ACT_UD), 32'hffff_ffff, "last");
        for (int n = 0; n < 120; n++)
        begin
            m_c0 = $random(seed) & 32'h0004_000e;
            m_c4 = $random(seed) & 32'h0000_0600;
            m_fl = $random(seed) & 32'h0004_0000;
            m_pv = 2'($random(seed));
            if (!m_c4[9])
                m_c4b = m_c4;
            wr(simd_gate_pkg::REG_CTRL0, m_c0);
            wr(simd_gate_pkg::REG_CTRL4, m_c4);
            wr(simd_gate_pkg::REG_FLAGS, m_fl);
            wr(simd_gate_pkg::REG_PRIV, {30'h0, m_pv});
            repeat (4)
            begin
                i = mk(cls[$unsigned($random(seed)) % 3],
                       szs[$unsigned($random(seed)) % 4],
                       4'($random(seed)), 1'($random(seed)));
                i.gen     = 3'h1 << ($unsigned($random(seed)) % 3);
                i.has_mem = 1'($random(seed));
                offer(i, 1'($random(seed)), 1'($random(seed)));
            end
        end
        conclude();
    end
endmodule : test_simd_ext_exception_gating

`default_nettype wire
